// ---- hw/moed_detect.sv ----
// Motion and orientation event detector with an AHB-Lite register slave.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module moed_detect
  import moed_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Filtered samples
  input wire logic sample_valid,
  input wire moed_sample_s sample,
  input wire logic [1:0] g_range,
  // Status for the interrupt mapping logic
  output logic [7:0] event_flags,
  output logic [2:0] orient_now
);

  function automatic logic [13:0] absv(input logic signed [13:0] v);
    absv = v[13] ? 14'(-v) : 14'(v);
  endfunction
  function automatic logic [15:0] scl(input logic [15:0] v, input logic [1:0] r);
    scl = v >> r;
  endfunction
  function automatic logic [12:0] sat1g(input logic [13:0] m, input logic [1:0] r);
    logic [13:0] lim;
    lim = ONE_G_LSB >> r;
    sat1g = (m > lim) ? lim[12:0] : m[12:0];
  endfunction
  function automatic logic [11:0] step_ms(input logic [11:0] c, input logic tick);
    step_ms = (tick && c != 12'hFFF) ? c + 12'h001 : c;
  endfunction

  function automatic logic [8:0] mot_delay(input logic [5:0] c);
    if (!c[5] && !c[4]) begin
      mot_delay = {5'h00, c[3:0]} + 9'h001;
    end else if (!c[5]) begin
      mot_delay = {2'h0, c[3:0], 3'h0} + 9'h028;
    end else begin
      mot_delay = {1'b0, c[4:0], 3'h0} + 9'h058;
    end
  endfunction

  // Bus slave: one wait state, so read data always leaves a flip-flop
  moed_bus_e bus_ff;
  logic [7:0] cfg_ff [64];
  logic [7:0] idx_ff;
  logic wr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic [7:0] status0_ff;
  logic [7:0] status3_ff;
  wire addr_ok = hsel && htrans[1] && hready;
  wire wr_now = (bus_ff == MOED_DATA) && wr_ff;
  wire idx_cfg = (idx_ff >= IDX_EN0) && (idx_ff <= IDX_LAST);
  wire [7:0] wmask = (idx_ff == IDX_CTRL) ? CTRL_WMASK : 8'hFF;
  wire [7:0] rd_byte = (idx_ff == IDX_STATUS0) ? status0_ff :
                       (idx_ff == IDX_STATUS3) ? status3_ff :
                       idx_cfg ? cfg_ff[idx_ff[5:0]] : 8'h00;
  wire latch_clr = wr_now && (idx_ff == IDX_CTRL) && hwdata[B_LATCH_CLR];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ff <= MOED_IDLE;
      idx_ff <= 8'h00;
      wr_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end else if (clk_en) begin
      if (bus_ff == MOED_DATA) begin
        bus_ff <= MOED_IDLE;
        hreadyout_ff <= 1'b1;
        hrdata_ff <= wr_ff ? hrdata_ff : {24'h00_0000, rd_byte};
      end else if (addr_ok) begin
        bus_ff <= MOED_DATA;
        hreadyout_ff <= 1'b0;
        idx_ff <= (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'hFF;
        wr_ff <= hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 64; i++) begin
        cfg_ff[i] <= CFG_RESET;
      end
    end else if (clk_en && wr_now && idx_cfg) begin
      cfg_ff[idx_ff[5:0]] <= hwdata[7:0] & wmask;
    end
  end
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;

  // Configuration fields
  wire [7:0] en0 = cfg_ff[IDX_EN0[5:0]];
  wire [7:0] en1 = cfg_ff[IDX_EN1[5:0]];
  wire [7:0] en2 = cfg_ff[IDX_EN2[5:0]];
  wire [7:0] hymode = cfg_ff[IDX_HYMODE[5:0]];
  wire [7:0] orcfg = cfg_ff[IDX_ORIENT[5:0]];
  wire [7:0] blkcfg = cfg_ff[IDX_BLOCK[5:0]];
  wire [7:0] flathold = cfg_ff[IDX_FLATHOLD[5:0]];
  wire [7:0] motdur = cfg_ff[IDX_MOTDUR[5:0]];
  wire latched_mode = cfg_ff[IDX_CTRL[5:0]][B_LATCH];
  wire [1:0] r = g_range;
  wire smp = clk_en && sample_valid;

  // Millisecond time base
  logic [31:0] pres_ff;
  wire ms_tick = clk_en && (pres_ff == 32'(MS_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pres_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      pres_ff <= ms_tick ? 32'h0000_0000 : pres_ff + 32'h0000_0001;
    end
  end

  // Magnitudes
  wire [13:0] mx = absv(sample.ax);
  wire [13:0] my = absv(sample.ay);
  wire [13:0] mz = absv(sample.az);
  wire [13:0] msx = absv(sample.sx);
  wire [13:0] msy = absv(sample.sy);
  wire [13:0] msz = absv(sample.sz);
  // Orientation code, x-y plane
  logic [2:0] orient_ff;
  logic orient_int_ff;
  logic [11:0] ostab_ff;
  wire [15:0] ohy = scl(ORHY_STEP * {13'h0, orcfg[6:4]}, r);
  wire [15:0] kx = (orcfg[1:0] == 2'b01) ? {1'b0, mx, 1'b0} :
                   (orcfg[1:0] == 2'b10) ? {3'h0, mx[13:1]} : {2'h0, mx};
  wire portrait = ({2'h0, my} + ohy) < kx;
  wire landscape = {2'h0, my} >= (kx + ohy);
  wire x_up = 17'(signed'(sample.ax)) >= signed'({1'b0, ohy});
  wire x_down = 17'(signed'(sample.ax)) < -signed'({1'b0, ohy});
  wire [1:0] xy_new = (portrait && x_up) ? 2'b00 :
                      (portrait && x_down) ? 2'b01 :
                      landscape ? {1'b1, ~sample.ay[13]} : orient_ff[1:0];
  // Z bit only flips once the new sign is clear of the flat region
  wire z_new = (sample.az[13] != orient_ff[2]) && ({2'h0, mz} > scl(Z_HYST, r)) ?
               sample.az[13] : orient_ff[2];
  wire [2:0] cand = {z_new, xy_new};

  // Blocking, tilt test on saturated values
  wire [12:0] tx = sat1g(mx, r);
  wire [12:0] ty = sat1g(my, r);
  wire [12:0] tz = sat1g(mz, r);
  wire [25:0] xy2 = 26'(tx * tx) + 26'(ty * ty);
  wire [25:0] z2 = 26'(tz * tz);
  wire theta_blk = {xy2, 6'h00} < 32'({26'h0, blkcfg[5:0]} * z2);
  wire big_acc = ({2'h0, mx} > scl(ACC_BLOCK, r)) || ({2'h0, my} > scl(ACC_BLOCK, r)) ||
                 ({2'h0, mz} > scl(ACC_BLOCK, r));
  wire [15:0] slope_lim = (orcfg[3:2] == 2'b11) ? scl(SLOPE_HI, r) : scl(SLOPE_LO, r);
  wire big_slope = ({2'h0, msx} > slope_lim) || ({2'h0, msy} > slope_lim) || ({2'h0, msz} > slope_lim);
  wire unstable = ostab_ff < 12'(ORIENT_STABLE_MS);
  wire blocked = (orcfg[3:2] == 2'b01) ? (theta_blk || big_acc) :
                 (orcfg[3:2] == 2'b10) ? (theta_blk || big_slope || big_acc) :
                 (orcfg[3:2] == 2'b11) ? (theta_blk || big_slope || big_acc || unstable) : 1'b0;
  wire [2:0] diff = (cand ^ orient_ff) & {blkcfg[B_UPDOWN], 2'b11};
  wire or_change = !blocked && (diff != 3'b000);
  wire or_move = !blocked && (cand != orient_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      orient_ff <= 3'b000;
      orient_int_ff <= 1'b0;
      ostab_ff <= 12'h000;
    end else if (clk_en) begin
      if (smp && or_move) begin
        orient_ff <= cand;
        ostab_ff <= 12'h000;
      end else begin
        ostab_ff <= step_ms(ostab_ff, ms_tick);
      end
      if (!en0[B_ORIENT]) begin
        orient_int_ff <= 1'b0;
      end else if (smp) begin
        orient_int_ff <= or_change;
      end
    end
  end

  // Flat position with hysteresis and hold time
  logic flat_raw_ff;
  logic flat_rep_ff;
  logic flat_int_ff;
  logic [11:0] fhold_ff;
  wire [5:0] ft = cfg_ff[IDX_FLATTH[5:0]][5:0];
  wire [2:0] fh = flathold[2:0];
  wire [17:0] f_a = 18'({12'h0, ft} * (18'h00400 - {15'h0, fh}));
  wire [17:0] f_b = {9'h0, fh, 6'h00};
  wire [17:0] set_thr = (f_a > f_b) ? f_a - f_b : 18'h00000;
  wire [17:0] rst_thr = 18'({12'h0, ft} * (18'h00400 + {15'h0, fh})) + f_b;
  wire [43:0] f_lhs = {2'h0, xy2, 16'h0000};
  wire flat_now = flat_raw_ff ? !(f_lhs > 44'(rst_thr * z2)) : (f_lhs < 44'(set_thr * z2));
  wire [11:0] hold_ms = (flathold[5:4] == 2'b00) ? 12'h000 : 12'(FLAT_HOLD_BASE_MS) << flathold[5:4];
  wire flat_fire = (flat_now != flat_rep_ff) && (fhold_ff >= hold_ms);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flat_raw_ff <= 1'b0;
      flat_rep_ff <= 1'b0;
      flat_int_ff <= 1'b0;
      fhold_ff <= 12'h000;
    end else if (clk_en) begin
      if (smp) begin
        flat_raw_ff <= flat_now;
        fhold_ff <= (flat_now == flat_rep_ff) ? 12'h000 : step_ms(fhold_ff, ms_tick);
      end else if (flat_raw_ff != flat_rep_ff) begin
        fhold_ff <= step_ms(fhold_ff, ms_tick);
      end
      if (smp && flat_fire) begin
        flat_rep_ff <= flat_now;
      end
      // A new flat event wins over the latch reset and over the self-clear
      if (!en0[B_FLAT]) begin
        flat_int_ff <= 1'b0;
      end else if (smp && flat_fire) begin
        flat_int_ff <= 1'b1;
      end else if (latched_mode ? latch_clr : smp) begin
        flat_int_ff <= 1'b0;
      end
    end
  end

  // Low-g
  logic low_int_ff;
  logic [11:0] low_ms_ff;
  wire [15:0] low_thr = scl(LOWTH_STEP * {8'h00, cfg_ff[IDX_LOWTH[5:0]]}, r);
  wire [15:0] freefall_hysteresis = scl(HY_STEP * {14'h0, hymode[1:0]}, r);
  wire [15:0] msum = {2'h0, mx} + {2'h0, my} + {2'h0, mz};
  wire low_below = hymode[B_LOW_MODE] ? (msum < low_thr) :
                   (({2'h0, mx} < low_thr) && ({2'h0, my} < low_thr) && ({2'h0, mz} < low_thr));
  wire [16:0] low_up = {1'b0, low_thr} + {1'b0, freefall_hysteresis};
  wire low_above = hymode[B_LOW_MODE] ? ({1'b0, msum} > low_up) :
                   (({3'h0, mx} > low_up) || ({3'h0, my} > low_up) || ({3'h0, mz} > low_up));
  wire [11:0] low_need = 12'(({4'h0, cfg_ff[IDX_LOWDUR[5:0]]} + 12'h001) * 12'(DUR_STEP_MS));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_int_ff <= 1'b0;
      low_ms_ff <= 12'h000;
    end else if (clk_en) begin
      if (smp && !low_below) begin
        low_ms_ff <= 12'h000;
      end else begin
        low_ms_ff <= step_ms(low_ms_ff, ms_tick);
      end
      if (!en1[B_LOW_EN]) begin
        low_int_ff <= 1'b0;
      end else if (smp && low_below && low_ms_ff >= low_need) begin
        low_int_ff <= 1'b1;
      end else if (smp && low_above) begin
        low_int_ff <= 1'b0;
      end
    end
  end

  // High-g with axis and sign capture
  logic high_int_ff;
  logic [11:0] high_ms_ff;
  logic [3:0] high_axis_ff;
  wire [15:0] hi_thr = HIGHTH_STEP * {8'h00, cfg_ff[IDX_HIGHTH[5:0]]};
  wire [15:0] hi_hy = HY_STEP * {14'h0, hymode[7:6]};
  wire [15:0] hi_low = (hi_thr > hi_hy) ? hi_thr - hi_hy : 16'h0000;
  wire [2:0] over = en1[2:0] & {({2'h0, mz} > hi_thr), ({2'h0, my} > hi_thr), ({2'h0, mx} > hi_thr)};
  wire [2:0] under = ~en1[2:0] | {({2'h0, mz} < hi_low), ({2'h0, my} < hi_low), ({2'h0, mx} < hi_low)};
  wire hi_cond = high_int_ff ? (under == 3'b111) : (over != 3'b000);
  wire [11:0] hi_need = 12'(({4'h0, cfg_ff[IDX_HIGHDUR[5:0]]} + 12'h001) * 12'(DUR_STEP_MS));
  wire [3:0] first = over[0] ? {sample.ax[13], 3'b001} :
                     over[1] ? {sample.ay[13], 3'b010} : {sample.az[13], 3'b100};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_int_ff <= 1'b0;
      high_ms_ff <= 12'h000;
      high_axis_ff <= 4'h0;
    end else if (clk_en) begin
      if ((smp && !hi_cond) || en1[2:0] == 3'b000) begin
        high_ms_ff <= 12'h000;
      end else if (smp && hi_cond && high_ms_ff >= hi_need) begin
        high_ms_ff <= 12'h000;
        high_int_ff <= !high_int_ff;
        high_axis_ff <= high_int_ff ? {high_axis_ff[3], 3'b000} : first;
      end else begin
        high_ms_ff <= step_ms(high_ms_ff, ms_tick);
      end
      if (en1[2:0] == 3'b000) begin
        high_int_ff <= 1'b0;
        high_axis_ff[2:0] <= 3'b000;
      end
    end
  end

  // Slow-motion and no-motion
  logic mot_int_ff;
  logic [1:0] slow_cnt_ff;
  logic [11:0] mot_ms_ff;
  logic [8:0] mot_sec_ff;
  wire [15:0] mot_thr = MOT_STEP * {8'h00, cfg_ff[IDX_MOTTH[5:0]]};
  wire [2:0] s_above = en2[2:0] & {({2'h0, msz} > mot_thr), ({2'h0, msy} > mot_thr), ({2'h0, msx} > mot_thr)};
  wire [2:0] s_below = ~en2[2:0] | {({2'h0, msz} < mot_thr), ({2'h0, msy} < mot_thr), ({2'h0, msx} < mot_thr)};
  wire still = s_below == 3'b111;
  wire no_mot = en2[B_MOT_SEL];
  wire slow_against = mot_int_ff ? (s_above == 3'b000) : (s_above != 3'b000);
  wire slow_done = slow_against && (slow_cnt_ff == motdur[3:2]);
  wire sec_tick = ms_tick && (mot_ms_ff == 12'(SEC_MS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mot_int_ff <= 1'b0;
      slow_cnt_ff <= 2'b00;
      mot_ms_ff <= 12'h000;
      mot_sec_ff <= 9'h000;
    end else if (clk_en) begin
      if (en2[2:0] == 3'b000) begin
        mot_int_ff <= 1'b0;
        slow_cnt_ff <= 2'b00;
      end else if (!no_mot && smp) begin
        slow_cnt_ff <= (slow_against && !slow_done) ? slow_cnt_ff + 2'b01 : 2'b00;
        if (slow_done) begin
          mot_int_ff <= !mot_int_ff;
        end
      end else if (no_mot && smp) begin
        mot_int_ff <= still && (mot_sec_ff >= mot_delay(motdur[7:2]));
      end
      if (!no_mot || (smp && !still)) begin
        mot_ms_ff <= 12'h000;
        mot_sec_ff <= 9'h000;
      end else if (ms_tick) begin
        mot_ms_ff <= sec_tick ? 12'h000 : mot_ms_ff + 12'h001;
        if (sec_tick && mot_sec_ff != 9'h1FF) begin
          mot_sec_ff <= mot_sec_ff + 9'h001;
        end
      end
    end
  end

  // Status registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status0_ff <= 8'h00;
      status3_ff <= 8'h00;
    end else if (clk_en) begin
      status0_ff <= {flat_int_ff, orient_int_ff, 2'b00, mot_int_ff, 1'b0, high_int_ff, low_int_ff};
      status3_ff <= {flat_rep_ff & en0[B_FLAT], orient_ff, high_axis_ff};
    end
  end

  assign event_flags = status0_ff;
  assign orient_now = status3_ff[6:4];
  wire unused_ok = &{1'b0, hsize, haddr[1:0], hwdata[31:8], hi_low[15]};

endmodule
`default_nettype wire

// ---- hw/moed_pkg.sv ----
// Package for the motion and orientation event detector: map, fields, scaling and timing.
package moed_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUR_STEP_MS = 2;
  localparam int ORIENT_STABLE_MS = 100;
  localparam int FLAT_HOLD_BASE_MS = 256;
  localparam int SEC_MS = 1000;
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_STATUS0 = 8'h09;
  localparam logic [7:0] IDX_STATUS3 = 8'h0C;
  localparam logic [7:0] IDX_EN0 = 8'h16;
  localparam logic [7:0] IDX_EN1 = 8'h17;
  localparam logic [7:0] IDX_EN2 = 8'h18;
  localparam logic [7:0] IDX_LOWDUR = 8'h22;
  localparam logic [7:0] IDX_LOWTH = 8'h23;
  localparam logic [7:0] IDX_HYMODE = 8'h24;
  localparam logic [7:0] IDX_HIGHDUR = 8'h25;
  localparam logic [7:0] IDX_HIGHTH = 8'h26;
  localparam logic [7:0] IDX_MOTDUR = 8'h27;
  localparam logic [7:0] IDX_MOTTH = 8'h29;
  localparam logic [7:0] IDX_ORIENT = 8'h2C;
  localparam logic [7:0] IDX_BLOCK = 8'h2D;
  localparam logic [7:0] IDX_FLATTH = 8'h2E;
  localparam logic [7:0] IDX_FLATHOLD = 8'h2F;
  localparam logic [7:0] IDX_CTRL = 8'h3F;
  localparam logic [7:0] IDX_LAST = 8'h3F;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h01;
  // Field positions
  localparam int B_LOW = 0;
  localparam int B_HIGH = 1;
  localparam int B_MOT = 3;
  localparam int B_ORIENT = 6;
  localparam int B_FLAT = 7;
  localparam int B_LOW_EN = 3;
  localparam int B_MOT_SEL = 3;
  localparam int B_LOW_MODE = 2;
  localparam int B_UPDOWN = 6;
  localparam int B_HIGH_SIGN = 3;
  localparam int B_LATCH = 0;
  localparam int B_LATCH_CLR = 1;
  // Scaling in output LSB at the 2 g range; shifted right by the range code, except HIGHTH_STEP, MOT_STEP and HY_STEP in the high-g hysteresis
  localparam logic [13:0] ONE_G_LSB = 14'h1000;
  localparam logic [15:0] LOWTH_STEP = 16'h0020;
  localparam logic [15:0] HY_STEP = 16'h0200;
  localparam logic [15:0] HIGHTH_STEP = 16'h0020;
  localparam logic [15:0] ORHY_STEP = 16'h0100;
  localparam logic [15:0] MOT_STEP = 16'h0010;
  localparam logic [15:0] Z_HYST = 16'h0333;
  localparam logic [15:0] SLOPE_LO = 16'h0333;
  localparam logic [15:0] SLOPE_HI = 16'h0666;
  localparam logic [15:0] ACC_BLOCK = 16'h1800;
  typedef struct packed {
    logic signed [13:0] ax;
    logic signed [13:0] ay;
    logic signed [13:0] az;
    logic signed [13:0] sx;
    logic signed [13:0] sy;
    logic signed [13:0] sz;
  } moed_sample_s;
  typedef enum logic {MOED_IDLE = 1'b0, MOED_DATA = 1'b1} moed_bus_e;
endpackage

// ---- testbench/moed_detect_assertions.sv ----
// Concurrent checks on the detector's bus and status ports.
`timescale 1ns/1ps
`default_nettype none
module moed_detect_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Samples and status
  input wire logic sample_valid,
  input wire logic [7:0] event_flags,
  input wire logic [2:0] orient_now
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic taken;
  assign taken = hsel && htrans[1] && hready && clk_en && hreadyout;
  okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  wait_state_a: assert property (taken |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(taken)) else $error("stray wait state");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h000000) else $error("hrdata upper bits set");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(taken && !hwrite, 2)) else $error("hrdata moved");
  orient_time_a: assert property ($changed(orient_now) |-> $past(sample_valid, 2) || $past(sample_valid, 3))
    else $error("orientation code moved off sample");
  flag_set_a: assert property ((event_flags & ~$past(event_flags)) != 8'h00 |-> $past(sample_valid, 2) || $past(sample_valid, 3))
    else $error("status set off sample");
  spare_bits_a: assert property (event_flags[5:4] == 2'b00 && !event_flags[2]) else $error("unused status bit set");
endmodule
bind moed_detect moed_detect_assertions chk_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sample_valid(sample_valid), .event_flags(event_flags), .orient_now(orient_now));
`default_nettype wire

// ---- testbench/moed_host.sv ----
// Host model: AHB-Lite master making single word transfers.
`timescale 1ns/1ps
`default_nettype none
module moed_host (
  // Clock and slave answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request
  output var logic hsel,
  output var logic [31:0] haddr,
  output var logic [1:0] htrans,
  output var logic hwrite,
  output var logic [31:0] hwdata
);
  logic [31:0] rd_q;
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
  end
  // Read right at the edge, before the slave's own updates of that edge land
  task automatic wait_rdy();
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd_q = hrdata;
  endtask
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_rdy();
    rd = rd_q;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the motion and orientation event detector.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import moed_pkg::*;
  localparam int MSC = 20;
  logic hclk, hresetn, clk_en, sample_valid, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [1:0] g_range;
  logic [2:0] orient_now;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] event_flags;
  moed_sample_s sample;
  int mismatches = 0;
  int samples_checked = 0;
  moed_detect #(.MS_CYC(MSC)) uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid), .sample(sample), .g_range(g_range),
    .event_flags(event_flags), .orient_now(orient_now));
  moed_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.xfer(idx, 1'b1, d, r);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    host.xfer(idx, 1'b0, 8'h00, r);
    chk("register", {24'h000000, exp}, r);
  endtask
  // One sample, then a millisecond of quiet so duration counters see real time
  task automatic smp(input int x, input int y, input int z, input int s);
    sample <= '{ax: 14'(x), ay: 14'(y), az: 14'(z), sx: 14'(s), sy: 14'h0000, sz: 14'h0000};
    sample_valid <= 1'b1;
    @(posedge hclk);
    sample_valid <= 1'b0;
    repeat (MSC) @(posedge hclk);
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    mismatches++;
    test_done();
  end
  initial begin
    hresetn = 1'b0;
    sample_valid = 1'b0;
    clk_en = 1'b1;
    g_range = 2'b00;
    sample = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(IDX_EN0, 8'h00);
    wr(IDX_EN1, 8'h0F);
    rdc(IDX_EN1, 8'h0F);
    wr(IDX_STATUS0, 8'hFF);
    rdc(IDX_STATUS0, 8'h00);
    wr(8'h01, 8'hFF);
    rdc(8'h01, 8'h00);
    wr(IDX_EN1, 8'h00);
    $display("test registers done");
    wr(IDX_EN0, 8'h40);
    wr(IDX_BLOCK, 8'h40);
    smp(0, 4096, 2048, 0);
    chk("orient", 3'b011, orient_now);
    chk("orient_int", 1'b1, event_flags[6]);
    smp(0, 4096, 2048, 0);
    chk("orient_int", 1'b0, event_flags[6]);
    smp(0, 4096, -4096, 0);
    chk("orient", 3'b111, orient_now);
    chk("orient_int", 1'b1, event_flags[6]);
    wr(IDX_BLOCK, 8'h00);
    smp(0, 4096, -4096, 0);
    smp(0, 4096, 4096, 0);
    chk("orient", 3'b011, orient_now);
    chk("orient_int", 1'b0, event_flags[6]);
    wr(IDX_ORIENT, 8'h04);
    smp(0, -8000, 4096, 0);
    chk("orient", 3'b011, orient_now);
    // A sample offered while the enable is low must not be taken
    clk_en <= 1'b0;
    smp(0, -4096, 4096, 0);
    clk_en <= 1'b1;
    chk("orient_frozen", 3'b011, orient_now);
    wr(IDX_EN0, 8'h00);
    $display("test orientation done");
    wr(IDX_EN1, 8'h07);
    wr(IDX_HIGHTH, 8'h40);
    repeat (4) smp(0, 0, -4096, 0);
    chk("high_int", 1'b1, event_flags[1]);
    host.xfer(IDX_STATUS3, 1'b0, 8'h00, r);
    chk("high_axis", 4'hC, r[3:0]);
    repeat (6) smp(0, 0, 0, 0);
    chk("high_int", 1'b0, event_flags[1]);
    $display("test high-g done");
    wr(IDX_EN1, 8'h08);
    wr(IDX_LOWTH, 8'h40);
    repeat (4) smp(0, 0, 0, 0);
    chk("low_int", 1'b1, event_flags[0]);
    smp(4096, 0, 0, 0);
    chk("low_int", 1'b0, event_flags[0]);
    // Low-g threshold is fixed in g, so fewer LSB at the wider range
    g_range <= 2'b01;
    repeat (4) smp(1500, 0, 0, 0);
    chk("low_range", 1'b0, event_flags[0]);
    g_range <= 2'b00;
    wr(IDX_HYMODE, 8'h04);
    repeat (4) smp(1000, 1000, 1000, 0);
    chk("low_sum", 1'b0, event_flags[0]);
    $display("test low-g done");
    wr(IDX_EN1, 8'h00);
    wr(IDX_EN2, 8'h07);
    wr(IDX_MOTTH, 8'h10);
    wr(IDX_MOTDUR, 8'h04);
    smp(0, 0, 0, 1000);
    chk("slow_int", 1'b0, event_flags[3]);
    smp(0, 0, 0, 1000);
    chk("slow_int", 1'b1, event_flags[3]);
    smp(0, 0, 0, 0);
    chk("slow_int", 1'b1, event_flags[3]);
    smp(0, 0, 0, 0);
    chk("slow_int", 1'b0, event_flags[3]);
    $display("test slow motion done");
    wr(IDX_EN2, 8'h0F);
    wr(IDX_MOTDUR, 8'h00);
    smp(0, 0, 0, 0);
    chk("nomot_int", 1'b0, event_flags[3]);
    repeat (SEC_MS * MSC) @(posedge hclk);
    smp(0, 0, 0, 0);
    chk("nomot_int", 1'b1, event_flags[3]);
    $display("test no motion done");
    wr(IDX_EN0, 8'h80);
    wr(IDX_FLATTH, 8'h08);
    smp(0, 0, 4096, 0);
    chk("flat_int", 1'b1, event_flags[7]);
    smp(0, 0, 4096, 0);
    chk("flat_int", 1'b0, event_flags[7]);
    wr(IDX_FLATHOLD, 8'h10);
    smp(4096, 0, 0, 0);
    chk("flat_hold", 1'b0, event_flags[7]);
    host.xfer(IDX_STATUS3, 1'b0, 8'h00, r);
    chk("flat_pos", 1'b1, r[7]);
    wr(IDX_FLATHOLD, 8'h00);
    wr(IDX_CTRL, 8'h01);
    smp(4096, 0, 0, 0);
    smp(4096, 0, 0, 0);
    chk("flat_latch", 1'b1, event_flags[7]);
    wr(IDX_CTRL, 8'h03);
    repeat (2) @(posedge hclk);
    chk("flat_latch", 1'b0, event_flags[7]);
    host.xfer(IDX_STATUS3, 1'b0, 8'h00, r);
    chk("flat_pos", 1'b0, r[7]);
    $display("test flat done");
    test_done();
  end
endmodule
`default_nettype wire
